// *** tc_defs.vh ***
// Purpose: Register map, field positions and reset values of the timer
// Assumes: Byte addressed classic Wishbone, 32-bit data
// Notes:   Definitions only
`ifndef TC_DEFS_VH
`define TC_DEFS_VH
// ==========================================================
// Register byte offsets
`define TC_CTRL      8'h00
`define TC_PER       8'h04
`define TC_CNT       8'h08
`define TC_STAT      8'h0c
`define TC_CC0       8'h10
`define TC_DTI       8'h20
`define TC_PAT       8'h24
`define TC_OUTCFG    8'h28
// ==========================================================
// Control fields
`define CF_PSEL_LO   0
`define CF_PSEL_HI   3
`define CF_SRC_LO    4
`define CF_SRC_HI    5
`define CF_MODE_LO   6
`define CF_MODE_HI   7
`define CF_DOWN      8
`define CF_HIRES     9
`define CF_DTI_EN    10
`define CF_PAT_EN    11
`define CF_SCMO      12
`define CF_FLT_EN    13
`define CF_NC_EN     14
`define CF_CAP_LO    16
`define CF_CAP_HI    17
// ==========================================================
// Encodings
`define SRC_OFF      2'h0
`define SRC_CLK      2'h1
`define SRC_EVT      2'h2
`define SRC_EXT      2'h3
`define MODE_FRQ     2'h0
`define MODE_SS      2'h1
`define MODE_DS      2'h2
`define MODE_CAPT    2'h3
`define CAP_NORM     2'h0
`define CAP_FRQ      2'h1
`define CAP_PW       2'h2
// ==========================================================
// Status bits and reset values
`define ST_OVF       0
`define ST_ERR       1
`define ST_CC0       2
`define ST_FAULT     6
`define PER_RST      16'hffff
`define NC_SAMPLES   4
`endif

// *** timer_pwm_deadtime_hires.v ***
// Purpose: 16-bit timer with compare/capture, waveform extension and
//          high resolution extension, on classic Wishbone
// Assumes: clk_i is the fast peripheral clock (four times the CPU rate)
// Notes:   Event inputs are on-chip and synchronous; ext_i is a pin
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "tc_defs.vh"

module timer_pwm_deadtime_hires #(
  parameter TYPE0 = 1                    // 1: type 0, 0: type 1
) (
  input  wire        clk_i,              // Fast peripheral clock
  input  wire        rst_i,              // Sync reset, active high
  input  wire        wb_cyc_i,           // Wishbone cycle
  input  wire        wb_stb_i,           // Wishbone strobe
  input  wire        wb_we_i,            // Wishbone write enable
  input  wire [7:0]  wb_adr_i,           // Byte address
  input  wire [3:0]  wb_sel_i,           // Byte lanes
  input  wire [31:0] wb_dat_i,           // Write data
  output reg  [31:0] wb_dat_o,           // Read data
  output reg         wb_ack_o,           // Acknowledge
  input  wire [7:0]  evt_i,              // Event channels
  input  wire        ext_i,              // External count pin
  input  wire [7:0]  port_out_i,         // Normal port output value
  output reg  [7:0]  pin_o,              // Port pin values
  output reg  [7:0]  evt_o               // Flag event pulses
);
  localparam NCH = TYPE0 ? 4 : 2;
  localparam AWX = TYPE0 ? 1'b1 : 1'b0;

  // Byte lane merge, used for the control register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  // Low half merge, so 16-bit registers take exactly 16 bits
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    begin
      merge16 = {sel[1] ? nw[15:8] : old[15:8],
                 sel[0] ? nw[7:0]  : old[7:0]};
    end
  endfunction

  // ==========================================================
  // Registers
  reg  [31:0] ctrl_r;
  reg  [15:0] per_buf_r, per_r;
  reg  [15:0] cnt_r;
  reg  [1:0]  sub_r;
  reg         down_r;
  reg  [17:0] ccb_r [0:3];
  reg  [17:0] cc_r  [0:3];
  reg  [15:0] dti_buf_r, dti_r;
  reg  [15:0] pat_buf_r, pat_r;
  reg  [15:0] outcfg_r;
  reg  [7:0]  stat_r;
  reg  [3:0]  wg_r;
  reg  [9:0]  pre_r;
  reg  [1:0]  ext_s_r;
  reg         ext_d_r;
  wire [7:0]  ls_w, hs_w;
  wire [3:0]  cap_rise, cap_fall;

  wire [1:0] src   = ctrl_r[`CF_SRC_HI:`CF_SRC_LO];
  wire [1:0] mode  = ctrl_r[`CF_MODE_HI:`CF_MODE_LO];
  wire [1:0] capm  = ctrl_r[`CF_CAP_HI:`CF_CAP_LO];
  wire       hires = ctrl_r[`CF_HIRES] & (src == `SRC_CLK);
  wire       pat_en = ctrl_r[`CF_PAT_EN] & AWX;
  wire       scmo  = ctrl_r[`CF_SCMO] & AWX;
  wire       dti_en = ctrl_r[`CF_DTI_EN] & AWX;
  wire       awx_on = pat_en | scmo | dti_en;

  // ==========================================================
  // Bus access: ack one cycle after strobe, write on ack edge
  wire        req = wb_cyc_i & wb_stb_i;
  wire        wr  = req & wb_we_i & wb_ack_o;
  wire [7:0]  wa  = {wb_adr_i[7:2], 2'b00};
  wire [31:0] wd  = wb_dat_i;
  reg  [31:0] rd;
  integer i;
  integer j, m, n;                       // One loop index per process

  // Read mux; unmapped addresses return zero
  always @*
  begin
    rd = 32'h0000_0000;
    case (wa)
      `TC_CTRL:   rd = ctrl_r;
      `TC_PER:    rd = {16'h0000, per_r};
      `TC_CNT:    rd = {14'h0000, cnt_r, sub_r};
      `TC_STAT:   rd = {24'h000000, stat_r};
      `TC_DTI:    rd = {16'h0000, dti_r};
      `TC_PAT:    rd = {16'h0000, pat_r};
      `TC_OUTCFG: rd = {16'h0000, outcfg_r};
      default:
      begin
        if (wa >= `TC_CC0 && wa < `TC_CC0 + 8'h10 &&
            wa[3:2] < NCH)
          rd = {14'h0000, cc_r[wa[3:2]]};
      end
    endcase
  end

  // Bus handshake registers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rd;
    end
  end

  // ==========================================================
  // Count source and prescaler
  // External pin passes two flops before edge detection
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_s_r <= 2'b00;
      ext_d_r <= 1'b0;
    end
    else
    begin
      ext_s_r <= {ext_s_r[0], ext_i};
      ext_d_r <= ext_s_r[1];
    end
  end

  wire src_ev = (src == `SRC_CLK) ? 1'b1 :
                (src == `SRC_EVT) ? evt_i[0] :
                (src == `SRC_EXT) ? (ext_s_r[1] & ~ext_d_r) : 1'b0;
  wire [9:0] pmask = (10'h001 << ctrl_r[`CF_PSEL_HI:`CF_PSEL_LO])
                     - 10'h001;
  // Hires bypasses the prescaler: fine steps every fast clock
  wire step = hires ? 1'b1 :
              src_ev & ((pre_r & pmask) == pmask);
  wire tick = step & (~hires | (sub_r == 2'b11));

  // Prescaler only advances on source events
  always @(posedge clk_i)
  begin
    if (rst_i)
      pre_r <= 10'h000;
    else if (src_ev && !hires)
      pre_r <= ((pre_r & pmask) == pmask) ? 10'h000 : pre_r + 10'h001;
  end

  // ==========================================================
  // Capture inputs: noise canceller and edge detect
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : g_cap
      reg [`NC_SAMPLES-1:0] smp_r;
      reg                   lvl_r;
      reg                   lvl_d_r;
      wire all1 = &smp_r;
      wire all0 = ~|smp_r;
      // Filter needs a stable run of samples before moving
      always @(posedge clk_i)
      begin
        if (rst_i || k >= NCH)
        begin
          smp_r   <= {`NC_SAMPLES{1'b0}};
          lvl_r   <= 1'b0;
          lvl_d_r <= 1'b0;
        end
        else
        begin
          smp_r   <= {smp_r[`NC_SAMPLES-2:0], evt_i[k]};
          lvl_d_r <= lvl_r;
          if (!ctrl_r[`CF_NC_EN])
            lvl_r <= evt_i[k];
          else if (all1 | all0)
            lvl_r <= all1;
        end
      end
      assign cap_rise[k] = lvl_r & ~lvl_d_r;
      assign cap_fall[k] = ~lvl_r & lvl_d_r;
    end
  endgenerate

  // ==========================================================
  // Counter, buffer transfer, flags and control writes
  wire        capt  = (mode == `MODE_CAPT);
  wire [15:0] top   = (mode == `MODE_FRQ) ? cc_r[0][17:2] : per_r;
  wire        stop  = (src == `SRC_OFF);
  reg         upd;
  reg         ovf;
  reg  [15:0] cnt_nxt;
  reg         dn_nxt;

  // Next count: wrap in single slope, turn round in dual slope
  always @*
  begin
    cnt_nxt = cnt_r;
    dn_nxt  = down_r;
    upd     = stop;
    ovf     = 1'b0;
    if (tick)
    begin
      if (mode == `MODE_DS)
      begin
        if (!down_r && cnt_r >= top)
        begin
          dn_nxt  = 1'b1;
          cnt_nxt = cnt_r - 16'h0001;
        end
        else if (down_r && cnt_r == 16'h0000)
        begin
          dn_nxt  = 1'b0;
          cnt_nxt = 16'h0001;
          ovf     = 1'b1;
          upd     = 1'b1;
        end
        else
          cnt_nxt = down_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
      end
      else if (ctrl_r[`CF_DOWN])
      begin
        cnt_nxt = (cnt_r == 16'h0000) ? top : cnt_r - 16'h0001;
        ovf     = (cnt_r == 16'h0000);
        upd     = ovf;
      end
      else
      begin
        cnt_nxt = (cnt_r >= top) ? 16'h0000 : cnt_r + 16'h0001;
        ovf     = (cnt_r >= top);
        upd     = ovf;
      end
    end
  end

  // Per-channel events: compare match or capture
  reg [3:0] ccset;
  reg       err_set;
  always @*
  begin
    ccset   = 4'h0;
    err_set = 1'b0;
    for (j = 0; j < NCH; j = j + 1)
    begin
      if (capt)
        ccset[j] = (capm == `CAP_PW) ? cap_fall[j] : cap_rise[j];
      else
        ccset[j] = step && {cnt_r, sub_r} == cc_r[j];
      if (capt && ccset[j] && stat_r[`ST_CC0 + j])
        err_set = 1'b1;
    end
  end

  wire restart = capt && (capm != `CAP_NORM) && |cap_rise[NCH-1:0];
  wire [7:0] st_clr = (wr && wa == `TC_STAT) ? wd[7:0] & {8{wb_sel_i[0]}}
                                              : 8'h00;
  wire flt_set = ctrl_r[`CF_FLT_EN] & |(evt_i & outcfg_r[15:8]);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r    <= 32'h0000_0000;
      per_buf_r <= `PER_RST;
      per_r     <= `PER_RST;
      cnt_r     <= 16'h0000;
      sub_r     <= 2'b00;
      down_r    <= 1'b0;
      dti_buf_r <= 16'h0000;
      dti_r     <= 16'h0000;
      pat_buf_r <= 16'h0000;
      pat_r     <= 16'h0000;
      outcfg_r  <= 16'h0000;
      stat_r    <= 8'h00;
      evt_o     <= 8'h00;
      for (i = 0; i < 4; i = i + 1)
      begin
        ccb_r[i] <= 18'h00000;
        cc_r[i]  <= 18'h00000;
      end
    end
    else
    begin
      // Fine sub-count only moves in high resolution
      sub_r  <= hires ? sub_r + 2'b01 : 2'b00;
      down_r <= dn_nxt;
      cnt_r  <= restart ? 16'h0000 : cnt_nxt;
      // Set wins over a simultaneous software clear
      stat_r <= (stat_r & ~st_clr) |
                {1'b0, flt_set & AWX, ccset, err_set, ovf};
      evt_o  <= {2'b00, ccset, err_set, ovf};
      // Buffered values go live only at the update point
      if (upd)
      begin
        per_r <= per_buf_r;
        dti_r <= dti_buf_r;
        pat_r <= pat_buf_r;
      end
      for (i = 0; i < NCH; i = i + 1)
      begin
        if (capt && ccset[i])
          cc_r[i] <= {cnt_r, 2'b00};
        else if (!capt && upd)
          cc_r[i] <= ccb_r[i];
      end
      if (wr)
      begin
        case (wa)
          `TC_CTRL:   ctrl_r <= merge(ctrl_r, wd, wb_sel_i);
          `TC_PER:    per_buf_r <= merge16(per_buf_r, wd, wb_sel_i);
          `TC_CNT:    cnt_r <= wd[17:2];
          `TC_DTI:    dti_buf_r <= merge16(dti_buf_r, wd, wb_sel_i);
          `TC_PAT:    pat_buf_r <= merge16(pat_buf_r, wd, wb_sel_i);
          `TC_OUTCFG: outcfg_r <= merge16(outcfg_r, wd, wb_sel_i);
          default:
          begin
            if (wa >= `TC_CC0 && wa < `TC_CC0 + 8'h10 &&
                wa[3:2] < NCH)
              ccb_r[wa[3:2]] <= wd[17:0];
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Waveform generators, one per channel
  always @(posedge clk_i)
  begin
    if (rst_i)
      wg_r <= 4'h0;
    else
      for (m = 0; m < 4; m = m + 1)
        if (m >= NCH || capt)
          wg_r[m] <= 1'b0;
        else if (mode == `MODE_FRQ)
          wg_r[m] <= (m == 0 && tick && cnt_r >= top) ? ~wg_r[m]
                                                     : wg_r[m];
        else
          wg_r[m] <= ({cnt_r, sub_r} < cc_r[m]);
  end

  // ==========================================================
  // Dead-time units: both sides off while the dead-time count runs
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : g_dti
      reg [7:0] dt_r;
      reg       wg_d_r;
      reg       ls_r;
      reg       hs_r;
      always @(posedge clk_i)
      begin
        if (rst_i || k >= NCH)
        begin
          dt_r   <= 8'h00;
          wg_d_r <= 1'b0;
          ls_r   <= 1'b0;
          hs_r   <= 1'b0;
        end
        else
        begin
          wg_d_r <= wg_r[k];
          if (wg_r[k] != wg_d_r)
          begin
            ls_r <= 1'b0;
            hs_r <= 1'b0;
            dt_r <= wg_r[k] ? dti_r[7:0] : dti_r[15:8];
          end
          else if (dt_r != 8'h00)
            dt_r <= dt_r - 8'h01;
          else
          begin
            ls_r <= wg_r[k];
            hs_r <= ~wg_r[k];
          end
        end
      end
      assign ls_w[2*k]   = ls_r;
      assign ls_w[2*k+1] = hs_r;
      assign hs_w[2*k]   = wg_r[k];
      assign hs_w[2*k+1] = 1'b0;
    end
  endgenerate

  // ==========================================================
  // Port override: pattern, single channel, dead time, plain
  reg [7:0] pin_nxt;
  reg       src_v;
  always @*
  begin
    pin_nxt = 8'h00;
    for (n = 0; n < 8; n = n + 1)
    begin
      if (pat_en)
        src_v = pat_r[8 + n];
      else if (scmo)
        src_v = wg_r[0];
      else if (dti_en)
        src_v = ls_w[n];
      else
        src_v = hs_w[n];
      if (awx_on && stat_r[`ST_FAULT])
        src_v = 1'b0;
      pin_nxt[n] = (pat_r[n] ? src_v : port_out_i[n])
                   ^ outcfg_r[n];
    end
  end

  // Pins leave from a flop
  always @(posedge clk_i)
  begin
    if (rst_i)
      pin_o <= 8'h00;
    else
      pin_o <= pin_nxt;
  end

endmodule

// *** timer_pwm_deadtime_hires_properties.sv ***
// Purpose: Port-level checks of the timer
// Assumes: Writes use all lanes; port value pairs never both high
// Notes:   Shadows of written registers tell the mode
`timescale 1ns/1ps
// ==========================================================
// Checker
module tc_props (
  input wire        clk_i,      // Clock
  input wire        rst_i,      // Reset
  input wire        wb_cyc_i,   // Cycle
  input wire        wb_stb_i,   // Strobe
  input wire        wb_we_i,    // Write
  input wire [7:0]  wb_adr_i,   // Address
  input wire [31:0] wb_dat_i,   // Write data
  input wire [31:0] wb_dat_o,   // Read data
  input wire        wb_ack_o,   // Acknowledge
  input wire [7:0]  port_out_i, // Port value
  input wire [7:0]  pin_o,      // Pins
  input wire [7:0]  evt_o       // Flag events
);
  reg  [17:0] ctl_r;  // Control shadow
  reg  [15:0] pat_r;  // Pattern shadow
  reg  [7:0]  inv_r;  // Invert shadow
  reg  [2:0]  q_r;    // Cycles since a write
  reg         per_r;  // Period written
  wire        wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire        off = ctl_r[5:4] == 2'h0;
  // Writes land at ack; pins lag, hence the settle count
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_r <= 18'h0;
      pat_r <= 16'h0;
      inv_r <= 8'h0;
      q_r   <= 3'h0;
      per_r <= 1'b0;
    end
    else
    begin
      q_r <= wr ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
      if (wr && wb_adr_i[7:2] == 6'h0)
        ctl_r <= wb_dat_i[17:0];
      if (wr && wb_adr_i[7:2] == 6'h1)
        per_r <= 1'b1;
      if (wr && wb_adr_i[7:2] == 6'h9)
        pat_r <= wb_dat_i[15:0];
      if (wr && wb_adr_i[7:2] == 6'ha)
        inv_r <= wb_dat_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Bus, then pins and flags
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request without ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i >= 8'h2c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_per_default: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h1 && !per_r
    |-> wb_dat_o == 32'hffff) else $error("period reset value");
  a_sides_apart: assert property (
    ctl_r[10] && !ctl_r[11] && !ctl_r[12] && inv_r == 8'h0 && q_r > 3'h1
    |-> (pin_o & (pin_o >> 1) & 8'h55) == 8'h0)
    else $error("both sides on");
  a_pattern_out: assert property (
    ctl_r[11] && off && !ctl_r[13] && q_r > 3'h3
    |-> pin_o == (((pat_r[15:8] & pat_r[7:0])
    | ($past(port_out_i) & ~pat_r[7:0])) ^ inv_r))
    else $error("pattern pins wrong");
  a_all_follow_a: assert property (
    ctl_r[12] && !ctl_r[11] && !ctl_r[10] && off
    && pat_r[7:0] == 8'hff && q_r > 3'h3
    |-> ((pin_o ^ inv_r) == 8'h00 || (pin_o ^ inv_r) == 8'hff))
    else $error("pins not all alike");
  a_idle_no_ovf: assert property (
    off && q_r > 3'h3 |-> !evt_o[0]) else $error("overflow while off");
endmodule
bind timer_pwm_deadtime_hires tc_props u_props (
  .clk_i      (clk_i),
  .rst_i      (rst_i),
  .wb_cyc_i   (wb_cyc_i),
  .wb_stb_i   (wb_stb_i),
  .wb_we_i    (wb_we_i),
  .wb_adr_i   (wb_adr_i),
  .wb_dat_i   (wb_dat_i),
  .wb_dat_o   (wb_dat_o),
  .wb_ack_o   (wb_ack_o),
  .port_out_i (port_out_i),
  .pin_o      (pin_o),
  .evt_o      (evt_o)
);

// *** event_system_model.sv ***
// Purpose: Event channels and count pin feeding the timer
// Assumes: Bench sets levels just after a clock edge
// Notes:   Events pass one register, as on-chip routing does
`timescale 1ns/1ps
// ==========================================================
// Event source
module event_system_model (
  input  wire       clk_i, // Clock
  input  wire [7:0] lvl_i, // Requested event levels
  input  wire       tgl_i, // Toggle count pin each cycle
  output reg  [7:0] evt_o, // Event channels
  output reg        ext_o  // External count pin
);
  // Start quiet so no stray event counts
  initial
  begin
    evt_o = 8'h0;
    ext_o = 1'b0;
  end
  // One stage of routing delay
  always @(posedge clk_i)
  begin
    evt_o <= lvl_i;
    if (tgl_i)
      ext_o <= ~ext_o;
  end
endmodule

// *** tb_timer_pwm_deadtime_hires.sv ***
// Purpose: Self-checking bench of the timer
// Assumes: Type 0 build; port value kept at 8'h5a
// Notes:   Capture checked by differences, free of fixed latency
`timescale 1ns/1ps
`include "tc_defs.vh"
`define CHK(g, e) \
  begin \
    checks = checks + 1; \
    if ((g) !== (e)) \
    begin \
      fail_count = fail_count + 1; \
      $display("unexpected at %0t: got %0h want %0h", $time, g, e); \
    end \
  end
// ==========================================================
// Bench
module tb_timer_pwm_deadtime_hires;
  reg         clk_i;
  reg         rst_i;
  reg         cyc;
  reg         stb;
  reg         we;
  reg  [7:0]  adr;
  reg  [3:0]  sel;
  reg  [31:0] wdat;
  reg  [7:0]  lvl;
  reg         tgl;
  reg  [7:0]  pout;
  wire [31:0] rdat;
  wire        ack;
  wire [7:0]  evt;
  wire        ext;
  wire [7:0]  pin;
  wire [7:0]  flg;
  reg  [31:0] v;
  reg  [31:0] c1;
  integer     fail_count;
  integer     checks;
  integer     ticks;
  integer     g;
  integer     i;
  timer_pwm_deadtime_hires #(.TYPE0(1)) uut (
    .clk_i (clk_i), .rst_i (rst_i), .wb_cyc_i (cyc), .wb_stb_i (stb),
    .wb_we_i (we), .wb_adr_i (adr), .wb_sel_i (sel), .wb_dat_i (wdat),
    .wb_dat_o (rdat), .wb_ack_o (ack), .evt_i (evt), .ext_i (ext),
    .port_out_i (pout), .pin_o (pin), .evt_o (flg));
  event_system_model u_evt (.clk_i (clk_i), .lvl_i (lvl), .tgl_i (tgl),
    .evt_o (evt), .ext_o (ext));
  // 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Hang guard, well above the fewer than a thousand cycles needed
  always @(posedge clk_i)
  begin
    ticks = ticks + 1;
    if (ticks == 20000)
    begin
      fail_count = fail_count + 1;
      close_out;
    end
  end
  task close_out;
  begin
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // Classic cycle: hold all until ack, take data at that edge
  task xfer(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    if (!w)
      v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d); xfer(1'b1, a, d); endtask
  task rd(input [7:0] a); xfer(1'b0, a, 32'h0); endtask
  task idle(input integer n); repeat (n) @(posedge clk_i); endtask
  task pulse(input [7:0] m, input integer w);
  begin
    @(posedge clk_i);
    lvl <= m;
    idle(w);
    lvl <= 8'h0;
  end
  endtask
  // Cycles between two overflow pulses
  task gap;
  begin
    while (flg[0] !== 1'b1)
      @(posedge clk_i);
    g = 0;
    @(posedge clk_i);
    while (flg[0] !== 1'b1)
    begin
      g = g + 1;
      @(posedge clk_i);
    end
    g = g + 1;
  end
  endtask
  function [31:0] ctl(input [1:0] m, input [1:0] s, input [3:0] p);
    ctl = {24'h0, m, s, p};
  endfunction
  // Main sequence
  initial
  begin
    {rst_i, cyc, stb, we, adr, wdat, lvl, tgl} = 1'b1 << 52;
    sel = 4'hf;
    pout = 8'h5a;
    fail_count = 0;
    checks = 0;
    ticks = 0;
    idle(6);
    rst_i <= 1'b0;
    rd(`TC_PER);
    `CHK(v, 32'hffff)
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c);
    `CHK(v, 32'h0)
    wr(`TC_DTI, 32'h0504);
    rd(`TC_DTI);
    `CHK(v, 32'h0504)
    $display("test registers done");
    wr(`TC_CC0, 32'h10);
    wr(`TC_PER, 32'h9);
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(`TC_CTRL, 32'h0);
      case (i)
        0: v = ctl(`MODE_SS, `SRC_CLK, 4'h0);
        1: v = ctl(`MODE_SS, `SRC_CLK, 4'h2);
        2: v = ctl(`MODE_DS, `SRC_CLK, 4'h0);
        3: v = ctl(`MODE_SS, `SRC_CLK, 4'h0) | 32'h200;
        4: v = ctl(`MODE_FRQ, `SRC_CLK, 4'h0);
        default: v = ctl(`MODE_SS, `SRC_CLK, 4'h0) | 32'h100;
      endcase
      wr(`TC_CTRL, v);
      gap;
      gap;
      case (i)
        0: `CHK(g, 10)
        1: `CHK(g, 40)
        2: `CHK(g, 18)
        3: `CHK(g, 40)
        4: `CHK(g, 5)
        default: `CHK(g, 10)
      endcase
    end
    $display("test counting done");
    wr(`TC_CTRL, 32'h0);
    wr(`TC_PER, 32'h100);
    wr(`TC_CNT, 32'h14);
    wr(`TC_CTRL, ctl(`MODE_SS, `SRC_EVT, 4'h0));
    repeat (3) pulse(8'h01, 1);
    idle(4);
    rd(`TC_CNT);
    `CHK(v, 32'h20)
    wr(`TC_CTRL, ctl(`MODE_SS, `SRC_EVT, 4'h0) | 32'h100);
    repeat (3) pulse(8'h01, 1);
    idle(4);
    rd(`TC_CNT);
    `CHK(v, 32'h14)
    wr(`TC_CTRL, ctl(`MODE_SS, `SRC_EXT, 4'h0));
    @(posedge clk_i);
    tgl <= 1'b1;
    idle(4);
    tgl <= 1'b0;
    idle(6);
    rd(`TC_CNT);
    `CHK(v, 32'h1c)
    $display("test events done");
    wr(`TC_CTRL, 32'h0);
    wr(`TC_STAT, 32'h7f);
    wr(`TC_CTRL, ctl(`MODE_CAPT, `SRC_CLK, 4'h0) | 32'h10000);
    pulse(8'h01, 1);
    idle(20);
    pulse(8'h01, 1);
    idle(8);
    rd(`TC_CC0);
    c1 = v;
    rd(`TC_STAT);
    `CHK(v & 32'h6, 32'h6)
    wr(`TC_CTRL, ctl(`MODE_CAPT, `SRC_CLK, 4'h0) | 32'h14000);
    wr(`TC_STAT, 32'h6);
    rd(`TC_STAT);
    `CHK(v & 32'h6, 32'h0)
    pulse(8'h01, 1);
    idle(12);
    rd(`TC_STAT);
    `CHK(v & 32'h4, 32'h0)
    pulse(8'h01, 6);
    idle(35);
    pulse(8'h01, 6);
    idle(16);
    rd(`TC_CC0);
    `CHK(v - c1, 32'h50)
    $display("test capture done");
    wr(`TC_CTRL, 32'h0);
    wr(`TC_OUTCFG, 32'hf0);
    idle(3);
    `CHK(pin, 8'haa)
    wr(`TC_PAT, 32'h3c0f);
    wr(`TC_CTRL, 32'h800);
    idle(3);
    `CHK(pin, 8'hac)
    wr(`TC_OUTCFG, 32'h0);
    wr(`TC_PAT, 32'h00ff);
    wr(`TC_CTRL, 32'h1000);
    idle(5);
    `CHK(pin === 8'h00 || pin === 8'hff, 1'b1)
    $display("test pins done");
    wr(`TC_CTRL, 32'h0);
    wr(`TC_PAT, 32'h0003);
    wr(`TC_DTI, 32'h0302);
    wr(`TC_OUTCFG, 32'h0400);
    wr(`TC_CC0, 32'h14);
    wr(`TC_PER, 32'h9);
    wr(`TC_CTRL, ctl(`MODE_SS, `SRC_CLK, 4'h0) | 32'h2400);
    g = 0;
    c1 = 0;
    repeat (40)
    begin
      @(posedge clk_i);
      g = g + (pin[0] === 1'b1);
      c1 = c1 + (pin[1:0] === 2'b00);
    end
    `CHK(g > 0 && g < 40, 1'b1)
    `CHK(c1 > 0, 1'b1)
    pulse(8'h04, 1);
    idle(4);
    rd(`TC_STAT);
    `CHK(v[6], 1'b1)
    g = 0;
    repeat (20)
    begin
      @(posedge clk_i);
      g = g + (pin[1:0] !== 2'b00);
    end
    `CHK(g, 0)
    wr(`TC_CTRL, 32'h0);
    wr(`TC_STAT, 32'h40);
    rd(`TC_STAT);
    `CHK(v[6], 1'b0)
    $display("test fault done");
    close_out;
  end
endmodule
